// ===== adc_ctrl_params.svh
// Register offsets, field positions and reset values of the converter control
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// Register offsets on the plain register port
`define REG_CTRL      4'h0
`define REG_DIV       4'h1
`define REG_CHSEL     4'h2
`define REG_CFG       4'h3
`define REG_STATUS    4'h4
`define REG_MASK      4'h5
`define REG_LIMIT_HI  4'h6
`define REG_LIMIT_LO  4'h7
`define REG_RESULT_HI 4'h8
`define REG_RESULT_LO 4'h9
`define REG_BND_FLAGS 4'hA
`define REG_CHANNEL   4'hB

// Control register fields
`define CTRL_EN       0
`define CTRL_MODE_LO  1
`define CTRL_MODE_HI  2
`define CTRL_RISE     3
`define CTRL_SCAN     4

// Configuration, status and mask fields
`define CFG_OUTSIDE   0
`define IRQ_DONE      0
`define IRQ_BND       1
`define STAT_BUSY     2

// Reset values
`define CTRL_RESET    8'h00
`define DIV_RESET     3'h7
`define CHSEL_RESET   8'h01
`define LIMIT_HI_RST  8'hFF
`define LIMIT_LO_RST  8'h00

`endif

// ===== adc_ctrl_pkg.sv
// Types shared by the converter control logic
package adc_ctrl_pkg;

	// Sequencer states, one-hot
	typedef enum logic [2:0]
	{
		ST_OFF  = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} seq_state_t;

	// Start condition selection
	typedef enum logic [1:0]
	{
		START_NONE  = 2'b00,
		START_TIMER = 2'b01,
		START_NOW   = 2'b10,
		START_EDGE  = 2'b11
	} start_mode_t;

	// Progress reported by the analog converter core
	typedef struct packed
	{
		logic       msb4_valid; // Four MSBs settled
		logic       msb8_valid; // Eight MSBs settled
		logic       done;       // Whole result settled
		logic [9:0] result;     // Partial or final result
	} core_status_t;

	// Commands to the analog converter core
	typedef struct packed
	{
		logic       start;   // Begin one conversion
		logic       clk_en;  // Converter clock enable
		logic [2:0] channel; // Input being converted
	} core_cmd_t;

endpackage

// ===== adc_conversion_control.sv
// Converter control: start modes, single-step scan, boundary limits, clock divider, power modes
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"

module adc_conversion_control
(
	input  wire logic                       clk,                    // 200 MHz clock
	input  wire logic                       srst,                   // Synchronous reset
	input  wire logic [3:0]                 reg_addr,               // Register address
	input  wire logic [7:0]                 reg_wdata,              // Write data
	input  wire logic                       reg_wr,                 // Write strobe
	input  wire logic                       reg_rd,                 // Read strobe
	output logic [7:0]                      reg_rdata,              // Read data, cycle after strobe
	input  wire logic                       timer0_overflow,        // Timer 0 overflow pulse
	input  wire logic                       conversion_trigger_pin, // Trigger pin level
	input  wire logic                       idle_mode,              // Device in idle
	input  wire logic                       power_down,             // Power-down or total power-down
	input  wire adc_ctrl_pkg::core_status_t core_status,            // From converter core
	output adc_ctrl_pkg::core_cmd_t         core_cmd,               // To converter core
	output logic                            irq,                    // Level interrupt
	output logic                            wake                    // Idle exit request
);
	import adc_ctrl_pkg::*;

	logic [7:0]  ctrl;
	logic [2:0]  div_sel;
	logic [7:0]  chsel;
	logic [7:0]  cfg;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [7:0]  limit_hi;
	logic [7:0]  limit_lo;
	logic [9:0]  result;
	logic [7:0]  boundary_channel_flags;
	logic [2:0]  channel;
	logic [2:0]  scan_ptr;
	logic [2:0]  div_cnt;
	logic        div_tick;
	logic        trig_prev;
	logic        early_hit;
	logic        start_now;
	logic        start_evt;
	logic        edge_evt;
	logic        bnd_hit;
	logic        rd_status;
	logic        rd_flags;
	seq_state_t  state;
	seq_state_t  next_state;
	start_mode_t mode;

	assign mode      = start_mode_t'(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
	assign rd_status = reg_rd && (reg_addr == `REG_STATUS);
	assign rd_flags  = reg_rd && (reg_addr == `REG_BND_FLAGS);

	// First selected channel at or after a starting point
	function automatic logic [2:0] pick_channel(input logic [7:0] sel, input logic [2:0] from);
		logic [2:0] c;
		logic       found;
		logic [2:0] idx;
		c     = from;
		found = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			idx = from + 3'(i);
			if (!found && sel[idx])
			begin
				c     = idx;
				found = 1'b1;
			end
		end
		return c;
	endfunction

	// Software-written registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl     <= `CTRL_RESET;
			div_sel  <= `DIV_RESET;
			chsel    <= `CHSEL_RESET;
			cfg      <= 8'h00;
			mask     <= 2'h0;
			limit_hi <= `LIMIT_HI_RST;
			limit_lo <= `LIMIT_LO_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`REG_CTRL:     ctrl     <= reg_wdata;
				`REG_DIV:      div_sel  <= reg_wdata[2:0];
				`REG_CHSEL:    chsel    <= reg_wdata;
				`REG_CFG:      cfg      <= reg_wdata;
				`REG_MASK:     mask     <= reg_wdata[1:0];
				`REG_LIMIT_HI: limit_hi <= reg_wdata;
				`REG_LIMIT_LO: limit_lo <= reg_wdata;
				default:       ;
			endcase
		end
	end

	// Writing the immediate mode starts one conversion; held while the sequencer steps out of OFF
	always_ff @(posedge clk)
	begin
		if (srst)
			start_now <= 1'b0;
		else
			start_now <= (reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_EN]
				&& (reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO] == START_NOW))
				|| (start_now && (state == ST_OFF) && ctrl[`CTRL_EN]); // Not lost on enable
	end

	// Trigger pin history; follows the pin through reset so no false edge follows it
	always_ff @(posedge clk)
	begin
		trig_prev <= conversion_trigger_pin;
	end

	// Chosen edge of the trigger pin
	assign edge_evt = ctrl[`CTRL_RISE] ? (conversion_trigger_pin && !trig_prev)
		: (!conversion_trigger_pin && trig_prev);

	// Start condition from the selected source
	always_comb
	begin
		case (mode)
			START_TIMER: start_evt = timer0_overflow;
			START_NOW:   start_evt = start_now;
			START_EDGE:  start_evt = edge_evt;
			default:     start_evt = 1'b0;
		endcase
	end

	// Sequencer: starts only taken while waiting, so triggers during a conversion are dropped
	always_comb
	begin
		case (state)
			ST_OFF:
				next_state = ctrl[`CTRL_EN] ? ST_WAIT : ST_OFF;
			ST_WAIT:
				if (!ctrl[`CTRL_EN])
					next_state = ST_OFF;
				else if (start_evt && (chsel != 8'h00) && !power_down)
					next_state = ST_CONV;
				else
					next_state = ST_WAIT;
			ST_CONV:
				if (!ctrl[`CTRL_EN])
					next_state = ST_OFF;
				else if (core_status.done && !power_down)
					next_state = ST_WAIT;
				else
					next_state = ST_CONV;
			default:
				next_state = ST_OFF;
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk)
	begin
		if (srst)
			state <= ST_OFF;
		else
			state <= next_state;
	end

	// Channel selection and scan pointer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			channel  <= 3'h0;
			scan_ptr <= 3'h0;
		end
		else if (!ctrl[`CTRL_SCAN] || (state == ST_OFF))
		begin
			scan_ptr <= 3'h0;
			if (state == ST_WAIT && next_state == ST_CONV)
				channel <= pick_channel(chsel, 3'h0);
		end
		else if (state == ST_WAIT && next_state == ST_CONV)
			channel <= pick_channel(chsel, scan_ptr);
		else if (state == ST_CONV && next_state == ST_WAIT)
			scan_ptr <= channel + 3'h1;
	end

	// Converter clock divider, frozen in power-down
	always_ff @(posedge clk)
	begin
		if (srst || state != ST_CONV)
			div_cnt <= 3'h0;
		else if (!power_down)
			div_cnt <= div_tick ? 3'h0 : div_cnt + 3'h1;
	end

	assign div_tick = (state == ST_CONV) && !power_down && (div_cnt == div_sel);

	// Core commands
	always_ff @(posedge clk)
	begin
		if (srst)
			core_cmd <= '0;
		else
		begin
			core_cmd.start   <= (state == ST_WAIT) && (next_state == ST_CONV);
			core_cmd.clk_en  <= div_tick;
			core_cmd.channel <= (state == ST_WAIT) ? pick_channel(chsel,
				ctrl[`CTRL_SCAN] ? scan_ptr : 3'h0) : channel;
		end
	end

	// Result capture
	always_ff @(posedge clk)
	begin
		if (srst)
			result <= 10'h000;
		else if (state == ST_CONV && core_status.done)
			result <= core_status.result;
	end

	// Boundary check: early four-MSB test in outside mode, then eight-MSB test
	always_comb
	begin
		bnd_hit = 1'b0;
		if (state == ST_CONV && mask[`IRQ_BND])
		begin
			if (core_status.msb4_valid && cfg[`CFG_OUTSIDE])
				bnd_hit = (core_status.result[9:6] > limit_hi[7:4])
					|| (core_status.result[9:6] < limit_lo[7:4]);
			else if (core_status.msb8_valid && !early_hit)
			begin
				if (cfg[`CFG_OUTSIDE])
					bnd_hit = (core_status.result[9:2] > limit_hi)
						|| (core_status.result[9:2] < limit_lo);
				else
					bnd_hit = (core_status.result[9:2] <= limit_hi)
						&& (core_status.result[9:2] >= limit_lo);
			end
		end
	end

	// One boundary hit per conversion
	always_ff @(posedge clk)
	begin
		if (srst || state != ST_CONV)
			early_hit <= 1'b0;
		else if (bnd_hit)
			early_hit <= 1'b1;
	end

	// Sticky status; an event in the clearing read cycle wins
	always_ff @(posedge clk)
	begin
		if (srst)
			status <= 2'h0;
		else
		begin
			status[`IRQ_DONE] <= (state == ST_CONV && core_status.done && !power_down)
				|| (status[`IRQ_DONE] && !rd_status);
			status[`IRQ_BND]  <= bnd_hit || (status[`IRQ_BND] && !rd_status);
		end
	end

	// Per-channel boundary flags
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : gen_flag
			always_ff @(posedge clk)
			begin
				if (srst)
					boundary_channel_flags[g] <= 1'b0;
				else
					boundary_channel_flags[g] <= (bnd_hit && channel == 3'(g))
						|| (boundary_channel_flags[g] && !rd_flags);
			end
		end
	endgenerate

	// Interrupt request and idle wake
	assign irq  = |(status & mask);
	assign wake = idle_mode && status[`IRQ_DONE] && mask[`IRQ_DONE];

	// Read data, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`REG_CTRL:      reg_rdata <= ctrl;
				`REG_DIV:       reg_rdata <= {5'h00, div_sel};
				`REG_CHSEL:     reg_rdata <= chsel;
				`REG_CFG:       reg_rdata <= cfg;
				`REG_STATUS:    reg_rdata <= {5'h00, state == ST_CONV, status};
				`REG_MASK:      reg_rdata <= {6'h00, mask};
				`REG_LIMIT_HI:  reg_rdata <= limit_hi;
				`REG_LIMIT_LO:  reg_rdata <= limit_lo;
				`REG_RESULT_HI: reg_rdata <= result[9:2];
				`REG_RESULT_LO: reg_rdata <= {6'h00, result[1:0]};
				`REG_BND_FLAGS: reg_rdata <= boundary_channel_flags;
				`REG_CHANNEL:   reg_rdata <= {5'h00, channel};
				default:        reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// Checks
	a_halt_after_done: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && core_status.done && !power_down && ctrl[`CTRL_EN]) |=> state == ST_WAIT)
		else $error("sequencer did not halt after conversion");
	a_only_selected: assert property (@(posedge clk) disable iff (srst)
		$rose(state == ST_CONV) |-> chsel[channel])
		else $error("unselected channel converted");
	a_timer_start: assert property (@(posedge clk) disable iff (srst)
		(state == ST_WAIT && mode == START_TIMER && timer0_overflow && ctrl[`CTRL_EN]
		&& chsel != 8'h00 && !power_down) |=> state == ST_CONV ##0 core_cmd.start)
		else $error("timer overflow did not start");
	a_ignore_busy: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && !core_status.done) |=> !core_cmd.start)
		else $error("start taken while converting");
	a_now_start: assert property (@(posedge clk) disable iff (srst)
		(reg_wr && reg_addr == `REG_CTRL && reg_wdata[2:0] == 3'h5 && state == ST_WAIT
		&& chsel != 8'h00 && !power_down && !timer0_overflow) |=> ##1 core_cmd.start)
		else $error("immediate mode did not start");
	a_edge_start: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && $past(state) == ST_CONV) |-> !core_cmd.start)
		else $error("edge restarted conversion");
	a_bnd_gated: assert property (@(posedge clk) disable iff (srst)
		(!mask[`IRQ_BND] && !status[`IRQ_BND]) |=> !status[`IRQ_BND])
		else $error("boundary flag set while disabled");
	a_early_hit: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && mask[`IRQ_BND] && cfg[`CFG_OUTSIDE] && core_status.msb4_valid
		&& core_status.result[9:6] > limit_hi[7:4]) |=> status[`IRQ_BND] && boundary_channel_flags[channel])
		else $error("early boundary hit missed");
	a_div_period: assert property (@(posedge clk) disable iff (srst)
		(div_tick && div_sel == 3'h2 && !power_down) |=> (!div_tick)[*2] ##1 (div_tick || power_down
		|| state != ST_CONV || $changed(div_sel)))
		else $error("divider period wrong");
	a_pd_frozen: assert property (@(posedge clk) disable iff (srst)
		power_down |=> !core_cmd.clk_en && !core_cmd.start)
		else $error("converter active in power-down");
	a_irq_level: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && core_status.done && !power_down && mask[`IRQ_DONE]
		&& !(reg_wr && reg_addr == `REG_MASK)) |=> irq)
		else $error("interrupt not raised");
	a_inside_hit: assert property (@(posedge clk) disable iff (srst)
		(state == ST_CONV && mask[`IRQ_BND] && !cfg[`CFG_OUTSIDE] && core_status.msb8_valid
		&& core_status.result[9:2] <= limit_hi && core_status.result[9:2] >= limit_lo) |=> status[`IRQ_BND])
		else $error("inside boundary hit missed");
	a_flag_channel: assert property (@(posedge clk) disable iff (srst)
		bnd_hit |=> boundary_channel_flags[channel])
		else $error("channel boundary flag not set");

endmodule

// ===== adc_core_model.sv
// Behavioural converter core answering start commands with staged progress pulses
`timescale 1ns/1ps
module adc_core_model
(
	input  wire logic                    clk,    // System clock
	input  wire logic                    srst,   // Synchronous reset
	input  wire adc_ctrl_pkg::core_cmd_t cmd,    // Commands from control
	input  wire logic [9:0]              value,  // Result to report
	output adc_ctrl_pkg::core_status_t   status  // Progress to control
);
	import adc_ctrl_pkg::*;
	int cnt;
	// Step through four-MSB, eight-MSB and final stages after each start
	always_ff @(posedge clk)
	begin
		if (srst || cmd.start)
			cnt <= srst ? 0 : 1;
		else if (cnt != 0)
			cnt <= (cnt == 30) ? 0 : cnt + 1;
	end
	// Result bus carries the inverse between stage pulses
	always_comb
	begin
		status.msb4_valid = (cnt == 4);
		status.msb8_valid = (cnt == 8);
		status.done       = (cnt == 30);
		status.result     = (cnt == 4 || cnt == 8 || cnt == 30) ? value : ~value;
	end
endmodule

// ===== adc_conversion_control_bench.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_conversion_control_bench;
	import adc_ctrl_pkg::*;
	logic         clk, srst, reg_wr, reg_rd, timer0_overflow, conversion_trigger_pin, idle_mode, power_down;
	logic [3:0]   reg_addr;
	logic [7:0]   reg_wdata, reg_rdata, d;
	logic [9:0]   value;
	logic         irq, wake;
	logic [2:0]   last_ch;
	core_status_t core_status;
	core_cmd_t    core_cmd;
	int           errors, tests_run, nst, cyc, lastc, gap, n0;

	adc_conversion_control u_adc_conversion_control (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer0_overflow(timer0_overflow), .conversion_trigger_pin(conversion_trigger_pin),
		.idle_mode(idle_mode), .power_down(power_down), .core_status(core_status),
		.core_cmd(core_cmd), .irq(irq), .wake(wake));
	adc_core_model u_adc_core_model (.clk(clk), .srst(srst), .cmd(core_cmd), .value(value), .status(core_status));

	// Clock generator
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Count starts, remember channel and converter clock spacing
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (core_cmd.start === 1'b1)
		begin
			nst <= nst + 1;
			last_ch <= core_cmd.channel;
		end
		if (core_cmd.clk_en === 1'b1)
		begin
			gap <= cyc - lastc;
			lastc <= cyc;
		end
	end
	// Compare and report
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Register bus cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	// Timer overflow pulse and trigger pin level
	task automatic tick;
		@(posedge clk);
		timer0_overflow <= 1'b1;
		@(posedge clk);
		timer0_overflow <= 1'b0;
	endtask
	task automatic pin(input logic v);
		@(posedge clk);
		conversion_trigger_pin <= v;
	endtask
	// Bounded wait for the end of a conversion, then one edge for the flags
	task automatic wdone;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (core_status.done !== 1'b1 && n < 200);
		if (n >= 200)
		begin
			errors++;
			close_out();
		end
		@(posedge clk);
		#1;
	endtask
	// Reset values, plus an unmapped address reading zero
	task automatic t_reset;
		logic [3:0] a[6] = '{`REG_CTRL, `REG_DIV, `REG_CHSEL, `REG_LIMIT_HI, `REG_LIMIT_LO, 4'hC};
		logic [7:0] e[6] = '{8'h00, 8'h07, 8'h01, 8'hFF, 8'h00, 8'h00};
		foreach (a[i])
		begin
			rd(a[i], d);
			chk(d, e[i]);
		end
		$display("reset values done");
	endtask
	// Immediate single-step scan over channels 1 and 3
	task automatic t_scan;
		logic [2:0] ex[3] = '{3'h1, 3'h3, 3'h1};
		n0 = nst;
		wr(`REG_CHSEL, 8'h0A);
		wr(`REG_MASK, 8'h01);
		foreach (ex[i])
		begin
			wr(`REG_CTRL, 8'h15);
			wdone();
			chk(last_ch, ex[i]);
			chk(irq, 1'b1);
			rd(`REG_STATUS, d);
			chk(d[0], 1'b1);
			chk(irq, 1'b0);
		end
		chk(16'(nst - n0), 16'h0003);
		$display("scan done");
	endtask
	// Timer start; overflows during a conversion are dropped
	task automatic t_timer;
		n0 = nst;
		wr(`REG_CTRL, 8'h13);
		tick();
		tick();
		wdone();
		chk(16'(nst - n0), 16'h0001);
		tick();
		wdone();
		chk(16'(nst - n0), 16'h0002);
		$display("timer done");
	endtask
	// Edge start in both directions; edges during a conversion are dropped
	task automatic t_edge;
		n0 = nst;
		wr(`REG_CTRL, 8'h1F);
		pin(1'b1);
		pin(1'b0);
		pin(1'b1);
		wdone();
		pin(1'b0);
		repeat (3) @(posedge clk);
		chk(16'(nst - n0), 16'h0001);
		pin(1'b1);
		wdone();
		wr(`REG_CTRL, 8'h17);
		pin(1'b0);
		wdone();
		chk(16'(nst - n0), 16'h0003);
		$display("edge done");
	endtask
	// Boundary criteria, early and late checks, enable off
	task automatic t_bound;
		logic [7:0] cf[5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
		logic [7:0] mk[5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
		logic [9:0] rs[5] = '{10'h3FF, 10'h214, 10'h0C0, 10'h0C0, 10'h0C0};
		logic       ht[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		wr(`REG_CHSEL, 8'h04);
		wr(`REG_LIMIT_HI, 8'h80);
		wr(`REG_LIMIT_LO, 8'h10);
		foreach (rs[i])
		begin
			value <= rs[i];
			wr(`REG_CFG, cf[i]);
			wr(`REG_MASK, mk[i]);
			wr(`REG_CTRL, 8'h05);
			wdone();
			chk(irq, ht[i]);
			rd(`REG_BND_FLAGS, d);
			chk(d, ht[i] ? 8'h04 : 8'h00);
			rd(`REG_STATUS, d);
			chk(d[1], ht[i]);
			rd(`REG_RESULT_HI, d);
			chk(d, rs[i][9:2]);
			rd(`REG_RESULT_LO, d);
			chk(d, {6'h00, rs[i][1:0]});
		end
		$display("boundary done");
	endtask
	// Converter clock spacing for several divider settings
	task automatic t_div;
		logic [2:0] dv[3] = '{3'h0, 3'h2, 3'h7};
		foreach (dv[i])
		begin
			wr(`REG_DIV, {5'h00, dv[i]});
			wr(`REG_CTRL, 8'h05);
			wdone();
			chk(16'(gap), 16'(dv[i]) + 16'h0001);
		end
		$display("divider done");
	endtask
	// Power-down blocks starts; idle completion wakes
	task automatic t_power;
		n0 = nst;
		@(posedge clk);
		power_down <= 1'b1;
		wr(`REG_CTRL, 8'h03);
		tick();
		repeat (4) @(posedge clk);
		chk(16'(nst - n0), 16'h0000);
		power_down <= 1'b0;
		idle_mode <= 1'b1;
		rd(`REG_STATUS, d);
		wr(`REG_MASK, 8'h01);
		wr(`REG_CTRL, 8'h05);
		chk(wake, 1'b0);
		wdone();
		chk(wake, 1'b1);
		rd(`REG_STATUS, d);
		chk(wake, 1'b0);
		$display("power done");
	endtask
	// Main sequence
	initial
	begin
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		timer0_overflow = 1'b0;
		conversion_trigger_pin = 1'b0;
		idle_mode = 1'b0;
		power_down = 1'b0;
		value = 10'h000;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_scan();
		t_timer();
		t_edge();
		t_bound();
		t_div();
		t_power();
		close_out();
	end
endmodule
